// File: src/pcs_clkdiv.sv
// Clock divider that toggles its output while running
`timescale 1ns/1ps
`include "pcs_map.svh"

module pcs_clkdiv
  import pcs_pkg::*;
#(
  parameter int DIV = `PCS_OP_DIV
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic run,
  output logic      clk_out
);

  localparam int HALF = (DIV / 2 < 1) ? 1 : DIV / 2;
  localparam int CW   = (HALF > 1) ? $clog2(HALF) : 1;
  localparam logic [CW-1:0] LAST = CW'(HALF - 1);

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic          out_reg;
  logic          out_next;

  // ****************************************************************
  // Divider
  // ****************************************************************
  always_comb begin
    cnt_next = '0;
    out_next = 1'b0;
    if (run) begin
      if (cnt_reg == LAST) begin
        out_next = ~out_reg;
      end else begin
        out_next = out_reg;
        cnt_next = cnt_reg + CW'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
      out_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      out_reg <= out_next;
    end
  end

  assign clk_out = out_reg;

  // Stopped divider holds its output low
  div_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
    !run |=> !out_reg)
    else $error("divider output not low while stopped");

endmodule

// File: src/pcs_map.svh
// Offsets, field positions, reset values and timing counts of the clock block
`ifndef PCS_MAP_SVH
`define PCS_MAP_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define PCS_CLK_MHZ          200
`define PCS_PLL_RST_MIN_NS   500
`define PCS_PLL_RST_MIN_CYC  ((`PCS_PLL_RST_MIN_NS*`PCS_CLK_MHZ+999)/1000)
`define PCS_HW_RST_MIN_US    300
`define PCS_HW_RST_MIN_CYC   (`PCS_HW_RST_MIN_US*`PCS_CLK_MHZ)
`define PCS_PLL_LOCK_NS      10000
`define PCS_PLL_LOCK_CYC     ((`PCS_PLL_LOCK_NS*`PCS_CLK_MHZ+999)/1000)
`define PCS_OP_DIV           2
`define PCS_MEM_DIV          2

// ****************************************************************
// Register offsets
// ****************************************************************
`define PCS_AW               12
`define PCS_CTRL_OFS         12'h000
`define PCS_STATUS_OFS       12'h004
`define PCS_MULT_OFS         12'h008

// ****************************************************************
// Fields
// ****************************************************************
`define PCS_CTRL_MEMSYNC     0
`define PCS_CTRL_RESET       1'h0
`define PCS_ST_SRCSEL        0
`define PCS_ST_RATE_LO       1
`define PCS_ST_RATE_HI       2
`define PCS_ST_PLLRDY        3
`define PCS_ST_RSVD          4
`define PCS_ST_CORERST       5
`define PCS_ST_MEMSYNC       6
`define PCS_ST_PLLSHORT      8
`define PCS_ST_HWSHORT       9
`define PCS_ST_XSEL          10
`define PCS_ST_XPAD          11
`define PCS_MULT_LO          0
`define PCS_MULT_HI          7
`define PCS_REF_LO           8
`define PCS_REF_HI           31

// ****************************************************************
// Rate select codes and multipliers
// ****************************************************************
`define PCS_RATE_13M5        2'h0
`define PCS_RATE_14M32       2'h1
`define PCS_RATE_17M73       2'h2
`define PCS_RATE_RSVD        2'h3
`define PCS_MULT_X15         8'h0f
`define PCS_MULT_X14         8'h0e
`define PCS_MULT_X11         8'h0b
`define PCS_MULT_NONE        8'h00
`define PCS_REF_13M5_KHZ     24'h0034bc
`define PCS_REF_14M32_KHZ    24'h0037f0
`define PCS_REF_17M73_KHZ    24'h004542
`define PCS_REF_NONE_KHZ     24'h000000

`endif

// File: src/pcs_pkg.sv
// Types shared by the clock block
package pcs_pkg;

  typedef enum logic [1:0] {
    PCS_PLL_OFF,
    PCS_PLL_LOCKING,
    PCS_PLL_RUN
  } pcs_pll_state_t;

endpackage

// File: src/pcs_pulse_chk.sv
// Measures a low pulse and flags a release that came too early
`timescale 1ns/1ps
`include "pcs_map.svh"

module pcs_pulse_chk
  import pcs_pkg::*;
#(
  parameter int MIN_CYC = `PCS_PLL_RST_MIN_CYC
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic lvl_n,
  output logic      short_pulse
);

  localparam int CW = $clog2(MIN_CYC + 1);
  localparam logic [CW-1:0] MINV = CW'(MIN_CYC);

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic          prev_reg;
  logic          short_reg;
  logic          short_next;

  // ****************************************************************
  // Low time counter
  // ****************************************************************
  always_comb begin
    cnt_next   = '0;
    short_next = 1'b0;
    if (!lvl_n) begin
      cnt_next = (cnt_reg == MINV) ? cnt_reg : cnt_reg + CW'(1);
    end else if (!prev_reg) begin
      short_next = (cnt_reg < MINV);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg   <= '0;
      prev_reg  <= 1'b1;
      short_reg <= 1'b0;
    end else begin
      cnt_reg   <= cnt_next;
      prev_reg  <= lvl_n;
      short_reg <= short_next;
    end
  end

  assign short_pulse = short_reg;

  pulse_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    short_reg |-> $past(lvl_n) && !$past(prev_reg) && $past(cnt_reg) < MINV)
    else $error("short pulse flagged without early release");

endmodule

// File: src/pcs_top.sv
// Clock source select, PLL control and reset front end with APB registers
//
// Contract
// - Source pin low picks PLL, high picks host clock
// - PLL yields 100 MHz operating, 200 MHz display
// - Rate code sets multiplier, code 11 reserved
// - Rate code acts only when PLL selected
// - Memory clock half PLL, or host clock
//
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "pcs_map.svh"

module pcs_top
  import pcs_pkg::*;
#(
  parameter int PLL_LOCK_CYC   = `PCS_PLL_LOCK_CYC,
  parameter int HW_RST_MIN_CYC = `PCS_HW_RST_MIN_CYC
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [`PCS_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              clock_source_select_pin,
  input  wire logic [1:0]        pll_input_rate_select,
  input  wire logic              host_bus_clock_input,
  input  wire logic              pll_reset_n,
  input  wire logic              hw_reset_n,
  input  wire logic              crystal_select_reserved,
  input  wire logic              crystal_pad_reserved_i,
  output logic                   crystal_pad_reserved_o,
  output logic                   crystal_pad_reserved_oe_n,
  output logic                   int_op_clk,
  output logic                   disp_ref_clk_en,
  output logic                   memory_clock_output,
  output logic                   core_reset_n,
  output logic                   pll_ready
);

  localparam int LCW = $clog2(PLL_LOCK_CYC + 1);
  localparam logic [LCW-1:0] LOCK_LAST = LCW'(PLL_LOCK_CYC - 1);

  // ****************************************************************
  // Multiplier selection
  // ****************************************************************
  logic [7:0]  mult_eff;
  logic [23:0] ref_eff;
  logic        rate_ok;

  always_comb begin
    mult_eff = `PCS_MULT_X14;
    ref_eff  = `PCS_REF_14M32_KHZ;
    rate_ok  = 1'b1;
    if (!clock_source_select_pin) begin
      case (pll_input_rate_select)
        `PCS_RATE_13M5: begin
          mult_eff = `PCS_MULT_X15;
          ref_eff  = `PCS_REF_13M5_KHZ;
        end
        `PCS_RATE_14M32: begin
          mult_eff = `PCS_MULT_X14;
          ref_eff  = `PCS_REF_14M32_KHZ;
        end
        `PCS_RATE_17M73: begin
          mult_eff = `PCS_MULT_X11;
          ref_eff  = `PCS_REF_17M73_KHZ;
        end
        default: begin
          mult_eff = `PCS_MULT_NONE;
          ref_eff  = `PCS_REF_NONE_KHZ;
          rate_ok  = 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // PLL control
  // ****************************************************************
  pcs_pll_state_t pll_state_reg;
  pcs_pll_state_t pll_state_next;
  logic [LCW-1:0] lock_cnt_reg;
  logic [LCW-1:0] lock_cnt_next;
  logic [7:0]     mult_reg;
  logic [23:0]    ref_reg;
  logic           pll_ready_reg;
  logic           pll_ready_next;
  logic           mult_chg;

  assign mult_chg = (mult_eff != mult_reg);

  always_comb begin
    pll_state_next = pll_state_reg;
    lock_cnt_next  = '0;
    case (pll_state_reg)
      PCS_PLL_OFF: begin
        if (pll_reset_n && rate_ok) begin
          pll_state_next = PCS_PLL_LOCKING;
        end
      end
      PCS_PLL_LOCKING: begin
        if (!pll_reset_n || !rate_ok) begin
          pll_state_next = PCS_PLL_OFF;
        end else if (!mult_chg) begin
          if (lock_cnt_reg == LOCK_LAST) begin
            pll_state_next = PCS_PLL_RUN;
          end else begin
            lock_cnt_next = lock_cnt_reg + LCW'(1);
          end
        end
      end
      PCS_PLL_RUN: begin
        if (!pll_reset_n || !rate_ok) begin
          pll_state_next = PCS_PLL_OFF;
        end else if (mult_chg) begin
          pll_state_next = PCS_PLL_LOCKING;
        end
      end
      default: begin
        pll_state_next = PCS_PLL_OFF;
      end
    endcase
    pll_ready_next = (pll_state_next == PCS_PLL_RUN);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_state_reg <= PCS_PLL_OFF;
      lock_cnt_reg  <= '0;
      mult_reg      <= `PCS_MULT_NONE;
      ref_reg       <= `PCS_REF_NONE_KHZ;
      pll_ready_reg <= 1'b0;
    end else begin
      pll_state_reg <= pll_state_next;
      lock_cnt_reg  <= lock_cnt_next;
      mult_reg      <= mult_eff;
      ref_reg       <= ref_eff;
      pll_ready_reg <= pll_ready_next;
    end
  end

  // ****************************************************************
  // Clock outputs and core reset
  // ****************************************************************
  logic mem_sync_reg;
  logic op_div_out;
  logic mem_div_out;
  logic int_op_clk_reg;
  logic int_op_clk_next;
  logic mem_clk_reg;
  logic mem_clk_next;
  logic disp_en_reg;
  logic core_rst_n_reg;

  pcs_clkdiv #(.DIV(`PCS_OP_DIV)) u_op_div (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (pll_ready_reg & ~clock_source_select_pin),
    .clk_out (op_div_out)
  );

  pcs_clkdiv #(.DIV(`PCS_MEM_DIV)) u_mem_div (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (pll_ready_reg & ~mem_sync_reg),
    .clk_out (mem_div_out)
  );

  always_comb begin
    int_op_clk_next = clock_source_select_pin ? host_bus_clock_input
                                              : op_div_out;
    mem_clk_next    = mem_sync_reg ? host_bus_clock_input
                                   : mem_div_out;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_op_clk_reg <= 1'b0;
      mem_clk_reg    <= 1'b0;
      disp_en_reg    <= 1'b0;
      core_rst_n_reg <= 1'b0;
    end else begin
      int_op_clk_reg <= int_op_clk_next;
      mem_clk_reg    <= mem_clk_next;
      disp_en_reg    <= pll_ready_reg;
      core_rst_n_reg <= hw_reset_n;
    end
  end

  // ****************************************************************
  // Power-up sequence monitors
  // ****************************************************************
  logic pll_short_pulse;
  logic hw_short_pulse;

  pcs_pulse_chk #(.MIN_CYC(`PCS_PLL_RST_MIN_CYC)) u_pll_rst_chk (
    .pclk        (pclk),
    .presetn     (presetn),
    .lvl_n       (pll_reset_n),
    .short_pulse (pll_short_pulse)
  );

  pcs_pulse_chk #(.MIN_CYC(HW_RST_MIN_CYC)) u_hw_rst_chk (
    .pclk        (pclk),
    .presetn     (presetn),
    .lvl_n       (hw_reset_n),
    .short_pulse (hw_short_pulse)
  );

  // ****************************************************************
  // APB slave
  // ****************************************************************
  logic        acc;
  logic        commit;
  logic        hit;
  logic [31:0] status_word;
  logic [31:0] rd_word;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic        pready_reg;
  logic        pready_next;
  logic        pslverr_reg;
  logic        pslverr_next;
  logic        mem_sync_next;
  logic        pll_short_reg;
  logic        pll_short_next;
  logic        hw_short_reg;
  logic        hw_short_next;

  assign acc    = psel & penable;
  assign commit = acc & pready_reg;

  always_comb begin
    status_word = '0;
    status_word[`PCS_ST_SRCSEL]  = clock_source_select_pin;
    status_word[`PCS_ST_RATE_HI:`PCS_ST_RATE_LO] = pll_input_rate_select;
    status_word[`PCS_ST_PLLRDY]  = pll_ready_reg;
    status_word[`PCS_ST_RSVD]    = ~rate_ok;
    status_word[`PCS_ST_CORERST] = ~core_rst_n_reg;
    status_word[`PCS_ST_MEMSYNC] = mem_sync_reg;
    status_word[`PCS_ST_PLLSHORT] = pll_short_reg;
    status_word[`PCS_ST_HWSHORT] = hw_short_reg;
    status_word[`PCS_ST_XSEL]    = crystal_select_reserved;
    status_word[`PCS_ST_XPAD]    = crystal_pad_reserved_i;
    rd_word = '0;
    hit     = 1'b1;
    case (paddr)
      `PCS_CTRL_OFS:   rd_word[`PCS_CTRL_MEMSYNC] = mem_sync_reg;
      `PCS_STATUS_OFS: rd_word = status_word;
      `PCS_MULT_OFS: begin
        rd_word[`PCS_MULT_HI:`PCS_MULT_LO] = mult_reg;
        rd_word[`PCS_REF_HI:`PCS_REF_LO]   = ref_reg;
      end
      default:         hit = 1'b0;
    endcase
    pready_next  = acc & ~pready_reg;
    prdata_next  = (pready_next && !pwrite) ? rd_word : '0;
    pslverr_next = pready_next & ~hit;
    mem_sync_next = mem_sync_reg;
    if (commit && pwrite && paddr == `PCS_CTRL_OFS) begin
      mem_sync_next = pwdata[`PCS_CTRL_MEMSYNC];
    end
    // Sticky flags: a new event wins over a clear in the same cycle
    pll_short_next = pll_short_pulse | (pll_short_reg & ~(commit & pwrite
                     & (paddr == `PCS_STATUS_OFS) & pwdata[`PCS_ST_PLLSHORT]));
    hw_short_next  = hw_short_pulse | (hw_short_reg & ~(commit & pwrite
                     & (paddr == `PCS_STATUS_OFS) & pwdata[`PCS_ST_HWSHORT]));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg    <= '0;
      pready_reg    <= 1'b0;
      pslverr_reg   <= 1'b0;
      mem_sync_reg  <= `PCS_CTRL_RESET;
      pll_short_reg <= 1'b0;
      hw_short_reg  <= 1'b0;
    end else begin
      prdata_reg    <= prdata_next;
      pready_reg    <= pready_next;
      pslverr_reg   <= pslverr_next;
      mem_sync_reg  <= mem_sync_next;
      pll_short_reg <= pll_short_next;
      hw_short_reg  <= hw_short_next;
    end
  end

  assign prdata                    = prdata_reg;
  assign pready                    = pready_reg;
  assign pslverr                   = pslverr_reg;
  assign int_op_clk                = int_op_clk_reg;
  assign disp_ref_clk_en           = disp_en_reg;
  assign memory_clock_output       = mem_clk_reg;
  assign core_reset_n              = core_rst_n_reg;
  assign pll_ready                 = pll_ready_reg;
  assign crystal_pad_reserved_o    = 1'b0;
  assign crystal_pad_reserved_oe_n = 1'b1;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence pll_rst_low_s;
    !pll_reset_n;
  endsequence

  sequence pll_down_s;
    !pll_ready_reg ##1 !disp_en_reg;
  endsequence

  src_host_a: assert property (
    clock_source_select_pin |=> int_op_clk_reg == $past(host_bus_clock_input))
    else $error("operating clock does not follow host clock");

  src_pll_a: assert property (
    (!clock_source_select_pin && pll_ready_reg)[*4]
    |-> int_op_clk_reg != $past(int_op_clk_reg))
    else $error("operating clock not at half PLL rate");

  mult_map_a: assert property (
    !clock_source_select_pin && pll_input_rate_select == `PCS_RATE_14M32
    |=> mult_reg == `PCS_MULT_X14)
    else $error("wrong multiplier for rate code");

  rsvd_rate_a: assert property (
    !clock_source_select_pin && pll_input_rate_select == `PCS_RATE_RSVD
    |=> !pll_ready_reg)
    else $error("PLL ready with reserved rate code");

  rate_ignore_a: assert property (
    clock_source_select_pin |=> mult_reg == `PCS_MULT_X14)
    else $error("rate code not ignored with host clock");

  mem_sync_a: assert property (
    mem_sync_reg |=> mem_clk_reg == $past(host_bus_clock_input))
    else $error("memory clock does not follow host clock");

  pll_gate_a: assert property (
    pll_rst_low_s |=> pll_down_s)
    else $error("PLL output used while PLL reset low");

  core_rst_a: assert property (
    !hw_reset_n |=> !core_rst_n_reg)
    else $error("core not held in reset");

  lock_time_a: assert property (
    $rose(pll_ready_reg) |-> $past(lock_cnt_reg) == LOCK_LAST)
    else $error("PLL ready before lock time");

  sticky_set_a: assert property (
    hw_short_pulse |=> hw_short_reg)
    else $error("short reset event lost");

  apb_ready_a: assert property (
    acc && !pready_reg |=> pready_reg ##1 !pready_reg)
    else $error("APB ready not a single cycle");

endmodule

// File: verif/pcs_board_model.sv
// Board oscillator, host bus clock and power-up reset sequencer model
`timescale 1ns/1ps

module pcs_board_model (
  input  wire logic        pclk,
  input  wire logic        start,
  input  wire logic [15:0] pll_low,
  input  wire logic [15:0] hw_low,
  output logic             host_bus_clock_input,
  output logic             pll_reset_n,
  output logic             hw_reset_n,
  output logic             crystal_select_reserved,
  output logic             crystal_pad_reserved_i,
  output logic             busy
);
  logic [1:0]  div;
  logic [1:0]  phase;
  logic [15:0] cnt;

  // Power-up: both resets held low until a sequence is started
  initial begin
    div = 2'h0;
    phase = 2'h0;
    cnt = 16'h0;
    busy = 1'b0;
    host_bus_clock_input = 1'b0;
    crystal_pad_reserved_i = 1'b0;
    pll_reset_n = 1'b0;
    hw_reset_n = 1'b0;
  end

  assign crystal_select_reserved = 1'b1;

  always @(posedge pclk) begin
    div <= div + 2'h1;
    // Host bus clock at a quarter of pclk, well under 100 MHz
    host_bus_clock_input <= div[1];
    // Open pad: no stable level, so it wanders every cycle
    crystal_pad_reserved_i <= ~crystal_pad_reserved_i;
    case (phase)
      2'h0: if (start) begin
        pll_reset_n <= 1'b0;
        hw_reset_n <= 1'b0;
        cnt <= pll_low;
        phase <= 2'h1;
        busy <= 1'b1;
      end
      2'h1: if (cnt <= 16'h1) begin
        pll_reset_n <= 1'b1;
        cnt <= hw_low;
        phase <= 2'h2;
      end else begin
        cnt <= cnt - 16'h1;
      end
      default: if (cnt <= 16'h1) begin
        hw_reset_n <= 1'b1;
        phase <= 2'h0;
        busy <= 1'b0;
      end else begin
        cnt <= cnt - 16'h1;
      end
    endcase
  end
endmodule

// File: verif/pll_clock_source_select_tb.sv
// Self-checking bench for the clock source select block
`timescale 1ns/1ps
`include "pcs_map.svh"

module pll_clock_source_select_tb
  import pcs_pkg::*;
();
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        clock_source_select_pin, host_bus_clock_input;
  logic [1:0]  pll_input_rate_select;
  logic        pll_reset_n, hw_reset_n, crystal_select_reserved;
  logic        crystal_pad_reserved_i, crystal_pad_reserved_o;
  logic        crystal_pad_reserved_oe_n, int_op_clk, disp_ref_clk_en;
  logic        memory_clock_output, core_reset_n, pll_ready;
  logic        start, busy, er;
  logic [15:0] pll_low, hw_low;
  int          miscompares, check_count;
  logic [7:0]  mult_exp [4] = '{`PCS_MULT_X15, `PCS_MULT_X14,
                                `PCS_MULT_X11, `PCS_MULT_NONE};
  logic [23:0] ref_exp [4] = '{`PCS_REF_13M5_KHZ, `PCS_REF_14M32_KHZ,
                               `PCS_REF_17M73_KHZ, `PCS_REF_NONE_KHZ};

  always #2.5 pclk = ~pclk;

  pcs_top #(.PLL_LOCK_CYC(4), .HW_RST_MIN_CYC(20)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .clock_source_select_pin(clock_source_select_pin),
    .pll_input_rate_select(pll_input_rate_select),
    .host_bus_clock_input(host_bus_clock_input),
    .pll_reset_n(pll_reset_n), .hw_reset_n(hw_reset_n),
    .crystal_select_reserved(crystal_select_reserved),
    .crystal_pad_reserved_i(crystal_pad_reserved_i),
    .crystal_pad_reserved_o(crystal_pad_reserved_o),
    .crystal_pad_reserved_oe_n(crystal_pad_reserved_oe_n),
    .int_op_clk(int_op_clk), .disp_ref_clk_en(disp_ref_clk_en),
    .memory_clock_output(memory_clock_output),
    .core_reset_n(core_reset_n), .pll_ready(pll_ready));

  pcs_board_model i_board (
    .pclk(pclk), .start(start), .pll_low(pll_low), .hw_low(hw_low),
    .host_bus_clock_input(host_bus_clock_input),
    .pll_reset_n(pll_reset_n), .hw_reset_n(hw_reset_n),
    .crystal_select_reserved(crystal_select_reserved),
    .crystal_pad_reserved_i(crystal_pad_reserved_i), .busy(busy));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task chk1(input string nm, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask

  task chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk1("pready", 1'b1, pready);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rd_chk(input logic [11:0] a, input logic [31:0] m,
              input logic [31:0] e, input logic ee, input string nm);
    apb(1'b0, a, 32'h0);
    chk32(nm, e, rd & m);
    chk1({nm, " error"}, ee, er);
  endtask

  task board_go(input logic [15:0] p, input logic [15:0] h);
    @(posedge pclk);
    pll_low <= p;
    hw_low <= h;
    start <= 1'b1;
    @(posedge pclk);
    start <= 1'b0;
    @(posedge pclk);
  endtask

  task board_wait;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    chk1("board idle", 1'b0, busy);
  endtask

  // Host mode: output follows host clock one cycle late, else toggles
  task chk_clk(input bit mem, input bit host);
    logic p, hp, v;
    @(negedge pclk);
    p = mem ? memory_clock_output : int_op_clk;
    hp = host_bus_clock_input;
    repeat (8) begin
      @(negedge pclk);
      v = mem ? memory_clock_output : int_op_clk;
      chk1(mem ? "memory clock" : "operating clock", host ? hp : ~p, v);
      p = v;
      hp = host_bus_clock_input;
    end
  endtask

  task final_report;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    #50000;
    miscompares++;
    final_report;
  end

  initial begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = 12'h0; pwdata = 32'h0; start = 1'b0;
    clock_source_select_pin = 1'b0; pll_input_rate_select = 2'h1;
    pll_low = 16'h0; hw_low = 16'h0; miscompares = 0; check_count = 0;
    repeat (10) @(posedge pclk);
    chk1("pad enable", 1'b1, crystal_pad_reserved_oe_n);
    chk1("pad output", 1'b0, crystal_pad_reserved_o);
    presetn <= 1'b1;
    board_go(16'd101, 16'd21);
    repeat (3) @(negedge pclk);
    chk1("core reset", 1'b0, core_reset_n);
    chk1("pll ready", 1'b0, pll_ready);
    chk1("operating clock", 1'b0, int_op_clk);
    chk1("display enable", 1'b0, disp_ref_clk_en);
    board_wait;
    repeat (8) @(negedge pclk);
    chk1("core reset", 1'b1, core_reset_n);
    chk1("pll ready", 1'b1, pll_ready);
    chk1("display enable", 1'b1, disp_ref_clk_en);
    chk_clk(1'b0, 1'b0);
    rd_chk(`PCS_CTRL_OFS, 32'hffffffff, 32'h0, 1'b0, "ctrl");
    for (int c = 0; c < 4; c++) begin
      @(posedge pclk);
      pll_input_rate_select <= c[1:0];
      repeat (20) @(posedge pclk);
      rd_chk(`PCS_MULT_OFS, 32'hffffffff, {ref_exp[c], mult_exp[c]},
             1'b0, "mult");
      rd_chk(`PCS_STATUS_OFS, 32'h7ff, {21'h0, 1'b1, 5'h0, (c == 3),
             (c != 3), c[1:0], 1'b0}, 1'b0, "status");
      chk1("pll ready", (c != 3), pll_ready);
    end
    clock_source_select_pin <= 1'b1;
    repeat (20) @(posedge pclk);
    chk_clk(1'b0, 1'b1);
    rd_chk(`PCS_MULT_OFS, 32'hffffffff,
           {`PCS_REF_14M32_KHZ, `PCS_MULT_X14}, 1'b0, "mult host");
    rd_chk(`PCS_STATUS_OFS, 32'h1, 32'h1, 1'b0, "source");
    clock_source_select_pin <= 1'b0;
    pll_input_rate_select <= 2'h1;
    repeat (20) @(posedge pclk);
    chk_clk(1'b1, 1'b0);
    apb(1'b1, `PCS_CTRL_OFS, 32'h1);
    rd_chk(`PCS_CTRL_OFS, 32'hffffffff, 32'h1, 1'b0, "ctrl");
    chk_clk(1'b1, 1'b1);
    rd_chk(`PCS_STATUS_OFS, 32'h40, 32'h40, 1'b0, "sync mode");
    apb(1'b1, `PCS_CTRL_OFS, 32'h0);
    rd_chk(12'h00c, 32'hffffffff, 32'h0, 1'b1, "unmapped");
    apb(1'b1, 12'h00c, 32'hffffffff);
    chk1("unmapped write error", 1'b1, er);
    rd_chk(`PCS_CTRL_OFS, 32'hffffffff, 32'h0, 1'b0, "ctrl kept");
    board_go(16'd10, 16'd5);
    board_wait;
    repeat (4) @(posedge pclk);
    rd_chk(`PCS_STATUS_OFS, 32'h300, 32'h300, 1'b0, "short");
    apb(1'b1, `PCS_STATUS_OFS, 32'h300);
    rd_chk(`PCS_STATUS_OFS, 32'h300, 32'h0, 1'b0, "cleared");
    final_report;
  end
endmodule
